// file: core/cmrsre_pkg.sv
package cmrsre_pkg;

  // ---------------------------------------------------------------
  // instruction word layout
  // ---------------------------------------------------------------
  localparam int unsigned INSTR_W    = 12;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FADDR_W    = 5;
  localparam int unsigned PC_W       = 11;
  localparam int unsigned DEST_BIT   = 5;
  localparam int unsigned OP6_LSB    = 6;
  localparam int unsigned OP4_LSB    = 8;

  // opcode fields; plain defaults, set to match the instruction decoder
  localparam logic [5:0] OP6_FILE_MOVE   = 6'h08;
  localparam logic [5:0] OP6_ROTATE_LEFT = 6'h0D;
  localparam logic [3:0] OP4_LITERAL     = 4'hC;
  localparam logic [3:0] OP4_RETURN_LIT  = 4'h8;
  localparam logic [INSTR_W-1:0] OPC_NOP    = 12'h000;
  localparam logic [INSTR_W-1:0] OPC_CONFIG = 12'h002;
  localparam logic [INSTR_W-1:0] OPC_SLEEP  = 12'h003;

  // ---------------------------------------------------------------
  // software register port
  // ---------------------------------------------------------------
  localparam int unsigned RADDR_W    = 4;
  localparam logic [RADDR_W-1:0] REG_CTRL   = 4'h0;
  localparam logic [RADDR_W-1:0] REG_STATUS = 4'h1;
  localparam logic [RADDR_W-1:0] REG_ACCUM  = 4'h2;
  localparam logic [RADDR_W-1:0] REG_CONFIG = 4'h3;

  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam int unsigned CTRL_WAKE_BIT = 1;

  localparam int unsigned ST_CARRY_BIT  = 0;
  localparam int unsigned ST_ZERO_BIT   = 2;
  localparam int unsigned ST_PWRDN_BIT  = 3;
  localparam int unsigned ST_TMOUT_BIT  = 4;
  localparam int unsigned ST_SLEEP_BIT  = 5;
  localparam int unsigned ST_ILLEGAL_BIT = 6;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] ACCUM_RST  = 8'h00;
  localparam logic [DATA_W-1:0] CONFIG_RST = 8'hFF;
  localparam logic              RUN_RST    = 1'b1;
  localparam logic              TMOUT_RST  = 1'b1;
  localparam logic              PWRDN_RST  = 1'b1;

  typedef enum logic [1:0] {
    CMRSRE_EXEC,
    CMRSRE_RET2,
    CMRSRE_SLEEP
  } cmrsre_state_e;

endpackage : cmrsre_pkg

// file: core/cmrsre_exec.sv
`timescale 1ns/1ps
// Summary of operation
// - file move goes to accumulator or back
// - file move updates zero from moved value
// - literal load fills accumulator, flags untouched
// - config load copies accumulator, flags untouched
// - return loads literal and stack top to pc
// - return with literal takes two cycles
// - sleep clears watchdog and its prescaler
// - sleep sets timeout, clears powerdown, keeps wakeup
// - sleep halts oscillator until wake
// - rotate left through carry, carry only affected
module cmrsre_exec
  import cmrsre_pkg::*;
(
  input  wire logic                          core_clk,
  input  wire logic                          sys_rst,
  // instruction stream
  input  wire logic [cmrsre_pkg::INSTR_W-1:0] instrWord,
  input  wire logic                          instrValid,
  output logic                               instrReady,
  // file register file
  output logic [cmrsre_pkg::FADDR_W-1:0]     fileRdAddr,
  input  wire logic [cmrsre_pkg::DATA_W-1:0] fileRdData,
  output logic                               fileWrEn,
  output logic [cmrsre_pkg::FADDR_W-1:0]     fileWrAddr,
  output logic [cmrsre_pkg::DATA_W-1:0]      fileWrData,
  // return stack and program counter
  input  wire logic [cmrsre_pkg::PC_W-1:0]   stackTopEntry,
  output logic                               stackPop,
  output logic                               pcLoad,
  output logic [cmrsre_pkg::PC_W-1:0]        pcLoadValue,
  // watchdog and power control
  output logic                               watchdogClear,
  output logic                               prescalerClear,
  output logic                               oscStop,
  input  wire logic                          wakeIn,
  input  wire logic                          pinChangeWakeupFlag,
  // configuration register contents
  output logic [cmrsre_pkg::DATA_W-1:0]      configReg,
  // software register port
  input  wire logic [cmrsre_pkg::RADDR_W-1:0] regAddr,
  input  wire logic [cmrsre_pkg::DATA_W-1:0] regWrData,
  input  wire logic                          regWr,
  input  wire logic                          regRd,
  output logic [cmrsre_pkg::DATA_W-1:0]      regRdData
);
  import cmrsre_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  cmrsre_state_e         state_ff,      nxt_state;
  logic [DATA_W-1:0]     accum_ff,      nxt_accum;
  logic [DATA_W-1:0]     config_ff,     nxt_config;
  logic                  zero_ff,       nxt_zero;
  logic                  carry_ff,      nxt_carry;
  logic                  timeout_ff,    nxt_timeout;
  logic                  powerdown_ff,  nxt_powerdown;
  logic                  illegal_ff,    nxt_illegal;
  logic                  run_ff,        nxt_run;
  logic                  fileWrEn_ff,   nxt_fileWrEn;
  logic [FADDR_W-1:0]    fileWrAddr_ff, nxt_fileWrAddr;
  logic [DATA_W-1:0]     fileWrData_ff, nxt_fileWrData;
  logic                  pcLoad_ff,     nxt_pcLoad;
  logic [PC_W-1:0]       pcValue_ff,    nxt_pcValue;
  logic                  pop_ff,        nxt_pop;
  logic                  wdogClr_ff,    nxt_wdogClr;
  logic [DATA_W-1:0]     rdData_ff,     nxt_rdData;

  logic                  take;
  logic                  destFile;
  logic [DATA_W-1:0]     rotated;
  logic                  wakeReq;

  function automatic logic is_op6(input logic [INSTR_W-1:0] w,
                                  input logic [5:0]         op);
    is_op6 = (w[INSTR_W-1:OP6_LSB] == op);
  endfunction : is_op6

  function automatic logic is_op4(input logic [INSTR_W-1:0] w,
                                  input logic [3:0]         op);
    is_op4 = (w[INSTR_W-1:OP4_LSB] == op);
  endfunction : is_op4

  // ---------------------------------------------------------------
  // combinational helpers
  // ---------------------------------------------------------------
  // a halted core accepts nothing; the second return cycle is a bubble
  assign instrReady = (state_ff == CMRSRE_EXEC) && run_ff;
  assign take       = instrValid && instrReady;
  assign fileRdAddr = instrWord[FADDR_W-1:0];
  assign destFile   = instrWord[DEST_BIT];
  assign rotated    = {fileRdData[DATA_W-2:0], carry_ff};
  assign wakeReq    = wakeIn ||
                      (regWr && regAddr == REG_CTRL &&
                       regWrData[CTRL_WAKE_BIT]);

  // ---------------------------------------------------------------
  // execution
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_state      = state_ff;
    nxt_accum      = accum_ff;
    nxt_config     = config_ff;
    nxt_zero       = zero_ff;
    nxt_carry      = carry_ff;
    nxt_timeout    = timeout_ff;
    nxt_powerdown  = powerdown_ff;
    nxt_illegal    = illegal_ff;
    nxt_fileWrEn   = 1'b0;
    nxt_fileWrAddr = fileWrAddr_ff;
    nxt_fileWrData = fileWrData_ff;
    nxt_pcLoad     = 1'b0;
    nxt_pcValue    = pcValue_ff;
    nxt_pop        = 1'b0;
    nxt_wdogClr    = 1'b0;
    unique case (state_ff)
      CMRSRE_EXEC:
      begin
        if (take)
        begin
          if (is_op6(instrWord, OP6_FILE_MOVE))
          begin
            nxt_zero = (fileRdData == '0);
            if (destFile)
            begin
              nxt_fileWrEn   = 1'b1;
              nxt_fileWrAddr = fileRdAddr;
              nxt_fileWrData = fileRdData;
            end
            else
            begin
              nxt_accum = fileRdData;
            end
          end
          else if (is_op6(instrWord, OP6_ROTATE_LEFT))
          begin
            nxt_carry = fileRdData[DATA_W-1];
            if (destFile)
            begin
              nxt_fileWrEn   = 1'b1;
              nxt_fileWrAddr = fileRdAddr;
              nxt_fileWrData = rotated;
            end
            else
            begin
              nxt_accum = rotated;
            end
          end
          else if (is_op4(instrWord, OP4_LITERAL))
          begin
            nxt_accum = instrWord[DATA_W-1:0];
          end
          else if (is_op4(instrWord, OP4_RETURN_LIT))
          begin
            // pc load and stack pop are registered, so pc and stack see the return in
            // the second cycle, which otherwise only flushes the prefetched word
            nxt_accum   = instrWord[DATA_W-1:0];
            nxt_pcLoad  = 1'b1;
            nxt_pcValue = stackTopEntry;
            nxt_pop     = 1'b1;
            nxt_state   = CMRSRE_RET2;
          end
          else if (instrWord == OPC_CONFIG)
          begin
            nxt_config = accum_ff;
          end
          else if (instrWord == OPC_SLEEP)
          begin
            nxt_wdogClr   = 1'b1;
            nxt_timeout   = 1'b1;
            nxt_powerdown = 1'b0;
            nxt_state     = CMRSRE_SLEEP;
          end
          else if (instrWord == OPC_NOP)
          begin
            nxt_state = CMRSRE_EXEC;
          end
          else
          begin
            // words outside this unit are flagged, otherwise a nop
            nxt_illegal = 1'b1;
          end
        end
      end
      CMRSRE_RET2:
      begin
        nxt_state = CMRSRE_EXEC;
      end
      CMRSRE_SLEEP:
      begin
        if (wakeReq)
        begin
          nxt_state = CMRSRE_EXEC;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------
  always_comb
  begin
    nxt_run    = run_ff;
    nxt_rdData = '0;
    if (regWr && regAddr == REG_CTRL)
    begin
      nxt_run = regWrData[CTRL_RUN_BIT];
    end
    if (regRd)
    begin
      unique case (regAddr)
        REG_CTRL:   nxt_rdData[CTRL_RUN_BIT] = run_ff;
        REG_STATUS:
        begin
          nxt_rdData[ST_CARRY_BIT]   = carry_ff;
          nxt_rdData[ST_ZERO_BIT]    = zero_ff;
          nxt_rdData[ST_PWRDN_BIT]   = powerdown_ff;
          nxt_rdData[ST_TMOUT_BIT]   = timeout_ff;
          nxt_rdData[ST_SLEEP_BIT]   = (state_ff == CMRSRE_SLEEP);
          nxt_rdData[ST_ILLEGAL_BIT] = illegal_ff;
          nxt_rdData[DATA_W-1]       = pinChangeWakeupFlag;
        end
        REG_ACCUM:  nxt_rdData = accum_ff;
        REG_CONFIG: nxt_rdData = config_ff;
        default:    nxt_rdData = '0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_ff      <= CMRSRE_EXEC;
      accum_ff      <= ACCUM_RST;
      config_ff     <= CONFIG_RST;
      zero_ff       <= 1'b0;
      carry_ff      <= 1'b0;
      timeout_ff    <= TMOUT_RST;
      powerdown_ff  <= PWRDN_RST;
      illegal_ff    <= 1'b0;
      run_ff        <= RUN_RST;
      fileWrEn_ff   <= 1'b0;
      fileWrAddr_ff <= '0;
      fileWrData_ff <= '0;
      pcLoad_ff     <= 1'b0;
      pcValue_ff    <= '0;
      pop_ff        <= 1'b0;
      wdogClr_ff    <= 1'b0;
      rdData_ff     <= '0;
    end
    else
    begin
      state_ff      <= nxt_state;
      accum_ff      <= nxt_accum;
      config_ff     <= nxt_config;
      zero_ff       <= nxt_zero;
      carry_ff      <= nxt_carry;
      timeout_ff    <= nxt_timeout;
      powerdown_ff  <= nxt_powerdown;
      illegal_ff    <= nxt_illegal;
      run_ff        <= nxt_run;
      fileWrEn_ff   <= nxt_fileWrEn;
      fileWrAddr_ff <= nxt_fileWrAddr;
      fileWrData_ff <= nxt_fileWrData;
      pcLoad_ff     <= nxt_pcLoad;
      pcValue_ff    <= nxt_pcValue;
      pop_ff        <= nxt_pop;
      wdogClr_ff    <= nxt_wdogClr;
      rdData_ff     <= nxt_rdData;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign fileWrEn       = fileWrEn_ff;
  assign fileWrAddr     = fileWrAddr_ff;
  assign fileWrData     = fileWrData_ff;
  assign pcLoad         = pcLoad_ff;
  assign pcLoadValue    = pcValue_ff;
  assign stackPop       = pop_ff;
  assign watchdogClear  = wdogClr_ff;
  assign prescalerClear = wdogClr_ff;
  // oscillator request is a level for the clock controller; this unit
  // keeps its clock so it can still see the wake request
  assign oscStop        = (state_ff == CMRSRE_SLEEP);
  assign configReg      = config_ff;
  assign regRdData      = rdData_ff;

endmodule : cmrsre_exec

// file: sim/cmrsre_exec_properties.sv
`timescale 1ns/1ps
module cmrsre_exec_properties
  import cmrsre_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] instrWord,
  input wire logic        instrValid,
  input wire logic        instrReady,
  input wire logic [7:0]  fileRdData,
  input wire logic        fileWrEn,
  input wire logic [4:0]  fileWrAddr,
  input wire logic [7:0]  fileWrData,
  input wire logic [10:0] stackTopEntry,
  input wire logic        stackPop,
  input wire logic        pcLoad,
  input wire logic [10:0] pcLoadValue,
  input wire logic        watchdogClear,
  input wire logic        prescalerClear,
  input wire logic        oscStop,
  input wire logic [7:0]  configReg
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // ------------------------------
  // decoded takes
  // ------------------------------
  wire logic take = instrValid && instrReady;
  wire logic dst  = instrWord[DEST_BIT];
  wire logic mvTk = take && instrWord[11:6] == OP6_FILE_MOVE;
  wire logic rlTk = take && instrWord[11:6] == OP6_ROTATE_LEFT;
  wire logic rtTk = take && instrWord[11:8] == OP4_RETURN_LIT;
  // ------------------------------
  // properties
  // ------------------------------
  property p_move_wb;
    mvTk && dst |=> fileWrEn && fileWrAddr == $past(instrWord[4:0])
      && fileWrData == $past(fileRdData);
  endproperty
  a_move_wb: assert property (p_move_wb)
    else $error("file move write-back wrong");
  property p_move_acc;
    mvTk && !dst |=> !fileWrEn;
  endproperty
  a_move_acc: assert property (p_move_acc)
    else $error("file move to accumulator wrote a file register");
  property p_rot_wb;
    rlTk && dst |=> fileWrEn && fileWrData[7:1] == $past(fileRdData[6:0]);
  endproperty
  a_rot_wb: assert property (p_rot_wb)
    else $error("rotate write-back wrong");
  property p_ret;
    rtTk |=> pcLoad && stackPop && pcLoadValue == $past(stackTopEntry);
  endproperty
  a_ret: assert property (p_ret)
    else $error("return did not load pc from stack top");
  property p_ret_gap;
    rtTk |=> !instrReady;
  endproperty
  a_ret_gap: assert property (p_ret_gap)
    else $error("return took a single cycle");
  property p_sleep;
    take && instrWord == OPC_SLEEP |=> watchdogClear && prescalerClear
      && oscStop;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep did not clear watchdog or stop oscillator");
  property p_cfg;
    !(take && instrWord == OPC_CONFIG) |=> $stable(configReg);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("configuration changed without its load");
  property p_nop;
    take && instrWord == OPC_NOP |=> !(fileWrEn || pcLoad || stackPop
      || watchdogClear);
  endproperty
  a_nop: assert property (p_nop)
    else $error("no-operation had a side effect");
endmodule : cmrsre_exec_properties

bind cmrsre_exec cmrsre_exec_properties i_cmrsre_exec_properties (
  .core_clk, .sys_rst, .instrWord, .instrValid, .instrReady, .fileRdData,
  .fileWrEn, .fileWrAddr, .fileWrData, .stackTopEntry, .stackPop, .pcLoad,
  .pcLoadValue, .watchdogClear, .prescalerClear, .oscStop, .configReg
);

// file: sim/cmrsre_exec_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, a) \
  begin \
    totalChecks++; \
    if ((a) !== (e)) \
    begin \
      failCount++; \
      $display("ERROR %s expected %0h seen %0h", n, e, a); \
    end \
  end
module cmrsre_exec_bench;
  import cmrsre_pkg::*;
  typedef struct {
    logic [11:0] w;
    logic [3:0]  a;
    logic [7:0]  m;
    logic [7:0]  e;
  } cmrsre_row_s;
  // ------------------------------
  // stimulus, file registers, design
  // ------------------------------
  logic        core_clk = 1'b0, sys_rst = 1'b1, instrValid = 1'b0;
  logic        wakeIn = 1'b0, regWr = 1'b0, regRd = 1'b0;
  logic        pinChangeWakeupFlag = 1'b1;
  logic [11:0] instrWord = 12'h000;
  logic [10:0] stackTopEntry = 11'h5A3;
  logic [3:0]  regAddr = 4'h0;
  logic [7:0]  regWrData = 8'h00;
  logic        instrReady, fileWrEn, stackPop, pcLoad, oscStop;
  logic        watchdogClear, prescalerClear;
  logic [4:0]  fileRdAddr, fileWrAddr;
  logic [7:0]  fileRdData, fileWrData, configReg, regRdData;
  logic [10:0] pcLoadValue;
  logic [7:0]  fileMem [32];
  int          failCount = 0, totalChecks = 0;
  // carry is cleared by reset, so the first rotate row shifts in a zero
  cmrsre_row_s rows [11] = '{
    '{12'hC5A, REG_ACCUM, 8'hFF, 8'h5A},
    '{OPC_CONFIG, REG_CONFIG, 8'hFF, 8'h5A},
    '{12'h34F, REG_ACCUM, 8'hFE, 8'hFE},
    '{OPC_NOP, REG_STATUS, 8'h19, 8'h19},
    '{12'h340, REG_ACCUM, 8'hFF, 8'h01},
    '{12'h220, REG_STATUS, 8'h1D, 8'h1C},
    '{12'h203, REG_ACCUM, 8'hFF, 8'h33},
    '{12'hC00, REG_STATUS, 8'h05, 8'h00},
    '{12'h8A5, REG_ACCUM, 8'hFF, 8'hA5},
    '{12'h223, REG_ACCUM, 8'hFF, 8'hA5},
    '{12'hFFF, REG_STATUS, 8'h40, 8'h40}
  };

  cmrsre_exec i_cmrsre_exec (
    .core_clk, .sys_rst, .instrWord, .instrValid, .instrReady,
    .fileRdAddr, .fileRdData, .fileWrEn, .fileWrAddr, .fileWrData,
    .stackTopEntry, .stackPop, .pcLoad, .pcLoadValue, .watchdogClear,
    .prescalerClear, .oscStop, .wakeIn, .pinChangeWakeupFlag,
    .configReg, .regAddr, .regWrData, .regWr, .regRd, .regRdData
  );

  always #4 core_clk = ~core_clk;
  // reads answer at once, writes land one edge after the pulse
  assign fileRdData = fileMem[fileRdAddr];
  always @(posedge core_clk)
    if (fileWrEn) fileMem[fileWrAddr] <= fileWrData;

  // ------------------------------
  // bus tasks and verdict
  // ------------------------------
  task automatic exec(input logic [11:0] ws [$]);
    foreach (ws[i])
    begin
      instrWord  <= ws[i];
      instrValid <= 1'b1;
      do @(posedge core_clk); while (instrReady !== 1'b1);
    end
    instrValid <= 1'b0;
  endtask : exec

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    regAddr   <= a;
    regWrData <= v;
    regWr     <= 1'b1;
    @(posedge core_clk) regWr <= 1'b0;
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [7:0] m, e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge core_clk) regRd <= 1'b0;
    @(posedge core_clk) `CHK($sformatf("reg %0h", a), e, regRdData & m)
  endtask : rchk

  task automatic printVerdict();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : printVerdict

  // whole run is under a hundred cycles; this leaves ample margin
  initial
  begin
    #20000;
    failCount++;
    printVerdict();
  end

  initial
  begin
    foreach (fileMem[i]) fileMem[i] = 8'(i * 17);
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(negedge core_clk) `CHK("configReg", 8'hFF, configReg)
    `CHK("oscStop", 1'b0, oscStop)
    @(posedge core_clk) rchk(REG_STATUS, 8'h18, 8'h18);
    foreach (rows[i])
    begin
      exec('{rows[i].w});
      rchk(rows[i].a, rows[i].m, rows[i].e);
    end
    `CHK("pcLoadValue", 11'h5A3, pcLoadValue)
    wr(REG_ACCUM, 8'hEE);
    exec('{12'h369, OPC_NOP, 12'h369});
    repeat (2) @(posedge core_clk);
    `CHK("fileMem9", 8'h65, fileMem[9])
    rchk(REG_ACCUM, 8'hFF, 8'hA5);
    exec('{OPC_SLEEP});
    rchk(REG_STATUS, 8'hF8, 8'hF0);
    wakeIn <= 1'b1;
    `CHK("oscStop", 1'b1, oscStop)
    `CHK("instrReady", 1'b0, instrReady)
    @(posedge core_clk) wakeIn <= 1'b0;
    @(negedge core_clk) `CHK("oscStop", 1'b0, oscStop)
    @(posedge core_clk) exec('{OPC_SLEEP});
    wr(REG_CTRL, 8'h03);
    @(negedge core_clk) `CHK("instrReady", 1'b1, instrReady)
    @(posedge core_clk) rchk(4'hF, 8'hFF, 8'h00);
    // halted core refuses words; a mid-run reset must bring run back
    wr(REG_CTRL, 8'h00);
    @(negedge core_clk) `CHK("instrReady", 1'b0, instrReady)
    @(posedge core_clk) rchk(REG_CTRL, 8'h01, 8'h00);
    sys_rst <= 1'b1;
    @(posedge core_clk) sys_rst <= 1'b0;
    @(negedge core_clk) `CHK("configReg", 8'hFF, configReg)
    `CHK("instrReady", 1'b1, instrReady)
    @(posedge core_clk) rchk(REG_STATUS, 8'h58, 8'h18);
    printVerdict();
  end
endmodule : cmrsre_exec_bench
